//--- src/chb_fir_coeff_taps.sv
// Channel B nine-tap equalization filter with its coefficient registers
//
// Operation
// (R1) The filter uses nine taps and treats each coefficient as signed two's complement.
// (R2) The channel B coefficients drive the filter only while dual-channel mode is set.
// (R3) The center tap is an 18-bit field in bits 17:0 of a 24-bit register, 23:18 reserved.
// (R4) The third tap is a 12-bit signed field in bits 11:0, bits 15:12 reserved.
// (R5) The fourth tap is a 12-bit signed field in bits 11:0 of a 16-bit register.
// (R6) The sixth tap is a 12-bit signed field in bits 11:0 of a 16-bit register.
// (R7) The seventh tap is a 12-bit signed field in bits 11:0 of a 16-bit register.
// (R8) All coefficient registers, reserved bits too, are read/write and clear to zero.
// (R9) The first and second taps are 12-bit signed values in registers of their own.
// (R10) The eighth and ninth taps are 12-bit signed values in registers of their own.
// (R11) Each output is the sum of the nine newest samples times their coefficients.
`timescale 1ns/1ns
module chb_fir_coeff_taps (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [23:0] rdata,
  input wire logic dual_mode,
  input wire logic [11:0] sample,
  input wire logic sample_valid,
  output logic [33:0] y,
  output logic y_valid
);

  typedef struct packed {
    logic [8:0][11:0] line;
    logic [33:0] y;
    logic y_valid;
    logic [23:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '0;

  state_s s_r;
  state_s s_nxt;

  logic [8:0][23:0] reg_val;
  logic [8:0] wr_hit;
  logic [8:0][11:0] line_shift;
  logic signed [29:0] prod [9];

  // Address decode; one register at most matches any address
  // (R4) (R5) third and fourth taps
  // (R6) (R7) sixth and seventh taps
  // (R9) (R10) outer tap registers
  always_comb begin
    for (int i = 0; i < fir_pkg::NUM_TAPS; i++) begin
      wr_hit[i] = wr && (addr == fir_pkg::TAP_OFFSETS[i]);
    end
  end

  // Newest sample enters at index 0, which the first tap multiplies
  assign line_shift = {s_r.line[7:0], sample};

  // Nine registers and nine multipliers; center tap is wider
  for (genvar g = 0; g < 9; g++) begin : g_tap
    localparam int RW = (g == fir_pkg::CENTER_IDX) ? fir_pkg::REG24_W : fir_pkg::REG16_W;
    localparam int CW = (g == fir_pkg::CENTER_IDX) ? fir_pkg::CENTER_W : fir_pkg::COEF_W;
    // (R3) register widths per tap
    coeff_reg #(.W(RW)) u_reg (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_hit[g]),
      .wdata(wdata),
      .value(reg_val[g])
    );
    // (R1) signed coefficient multiply
    fir_tap_mult #(.CW(CW)) u_mult (
      .sample(line_shift[g]),
      .coeff(reg_val[g][CW-1:0]),
      .product(prod[g])
    );
  end

  // Next state: read path, delay line and accumulation
  always_comb begin
    logic signed [33:0] acc;
    acc = '0;
    s_nxt = s_r;
    // (R8) read back full register
    s_nxt.rdata = fir_pkg::COEF_RESET;
    if (rd) begin
      for (int i = 0; i < fir_pkg::NUM_TAPS; i++) begin
        if (addr == fir_pkg::TAP_OFFSETS[i]) begin
          s_nxt.rdata = reg_val[i];
        end
      end
    end
    // (R11) nine-product sum
    for (int i = 0; i < fir_pkg::NUM_TAPS; i++) begin
      acc = acc + (fir_pkg::ACC_W)'(prod[i]);
    end
    s_nxt.y_valid = 1'b0;
    // (R2) dual mode gating
    if (!dual_mode) begin
      s_nxt.line = '0;
      s_nxt.y = '0;
    end else if (sample_valid) begin
      s_nxt.line = line_shift;
      s_nxt.y = acc;
      s_nxt.y_valid = 1'b1;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign y = s_r.y;
  assign y_valid = s_r.y_valid;

  // Checks on the register file and datapath
  a_reset_clears: assert property (@(posedge clk) $rose(rst_n) |-> reg_val == '0) // (R8)
    else $error("coefficients not zero after reset");
  a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rd) |-> rdata == 24'h00_0000) // (R8)
    else $error("read data outside read slot");
  a_center_full: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == fir_pkg::OFF_CENTER |=> reg_val[4] == $past(wdata)) // (R3)
    else $error("center register lost bits");
  a_tap3_width: assert property (@(posedge clk) disable iff (!rst_n)
    reg_val[2][23:16] == 8'h00 && reg_val[3][23:16] == 8'h00) // (R4)
    else $error("tap3 or tap4 above 16 bits");
  a_tap4_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == fir_pkg::OFF_TAP4) ##1 (rd && addr == fir_pkg::OFF_TAP4)
    |=> rdata == ($past(wdata, 2) & 24'h00_ffff)) // (R5)
    else $error("tap4 read back mismatch");
  a_tap6_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == fir_pkg::OFF_TAP6 |=> reg_val[5] == ($past(wdata) & 24'h00_ffff)) // (R6)
    else $error("tap6 write mismatch");
  a_tap7_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == fir_pkg::OFF_TAP7 |=> reg_val[6] == ($past(wdata) & 24'h00_ffff)) // (R7)
    else $error("tap7 write mismatch");
  a_single_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !dual_mode |=> y == '0 && !y_valid) // (R2)
    else $error("output active outside dual mode");
  a_valid_follows: assert property (@(posedge clk) disable iff (!rst_n)
    dual_mode && sample_valid |=> y_valid ##1 (y_valid == $past(sample_valid && dual_mode))) // (R11)
    else $error("output valid does not track samples");

endmodule : chb_fir_coeff_taps

//--- inc/fir_pkg.sv
// Constants shared by the channel B equalization filter coefficient block
package fir_pkg;

  // Register port widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 24;

  // Coefficient register offsets, outer taps included
  localparam logic [11:0] OFF_TAP1 = 12'h448;
  localparam logic [11:0] OFF_TAP2 = 12'h44a;
  localparam logic [11:0] OFF_TAP3 = 12'h44c;
  localparam logic [11:0] OFF_TAP4 = 12'h44e;
  localparam logic [11:0] OFF_CENTER = 12'h450;
  localparam logic [11:0] OFF_TAP6 = 12'h453;
  localparam logic [11:0] OFF_TAP7 = 12'h455;
  localparam logic [11:0] OFF_TAP8 = 12'h457;
  localparam logic [11:0] OFF_TAP9 = 12'h459;

  // Offset table, index 0 is the first tap
  localparam logic [8:0][11:0] TAP_OFFSETS = {
    OFF_TAP9, OFF_TAP8, OFF_TAP7, OFF_TAP6, OFF_CENTER,
    OFF_TAP4, OFF_TAP3, OFF_TAP2, OFF_TAP1
  };

  // Tap count and field layout
  localparam int NUM_TAPS = 9;
  localparam int CENTER_IDX = 4;
  localparam int REG16_W = 16;
  localparam int REG24_W = 24;
  localparam int COEF_W = 12;
  localparam int CENTER_W = 18;

  // Datapath widths
  localparam int SAMPLE_W = 12;
  localparam int PROD_W = 30;
  localparam int ACC_W = 34;

  // Reset value of every coefficient register
  localparam logic [23:0] COEF_RESET = 24'h00_0000;

endpackage : fir_pkg

//--- src/coeff_reg.sv
// One read/write coefficient register, reserved bits stored as well
`timescale 1ns/1ns
module coeff_reg #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [23:0] wdata,
  output logic [23:0] value
);

  typedef struct packed {
    logic [W-1:0] value;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Whole register width is kept, so reserved bits read back as written
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      s_nxt.value = wdata[W-1:0];
    end
  end

  // Synchronous clear to the documented zero value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r.value <= fir_pkg::COEF_RESET[W-1:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bits above the register width read as zero
  assign value = (fir_pkg::DATA_W)'(s_r.value);

endmodule : coeff_reg

//--- src/fir_tap_mult.sv
// Signed product of one sample and one tap coefficient
`timescale 1ns/1ns
module fir_tap_mult #(
  parameter int CW = 12
) (
  input wire logic [11:0] sample,
  input wire logic [CW-1:0] coeff,
  output logic signed [29:0] product
);

  logic signed [17:0] coeff_ext;

  // Sign extension keeps narrow taps in two's complement
  assign coeff_ext = (fir_pkg::CENTER_W)'($signed(coeff));
  assign product = $signed(sample) * coeff_ext;

endmodule : fir_tap_mult

//--- bench/chb_fir_coeff_taps_tb.sv
// Self-checking bench for the channel B equalization filter coefficient block
`timescale 1ns/1ns
module chb_fir_coeff_taps_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, dual_mode = 0, sample_valid = 0;
  logic [11:0] addr = '0, sample = '0;
  logic [23:0] wdata = '0, rdata;
  logic [33:0] y;
  logic y_valid;
  int n_mismatch = 0, checked = 0, cyc = 0, cf[9];
  // Rows: address, write data, expected read back; 16-bit registers drop the top byte
  logic [59:0] rows[6] = '{{12'h44c, 24'hff_ffff, 24'h00_ffff},
    {12'h44e, 24'h12_a5a5, 24'h00_a5a5}, {12'h450, 24'hfe_dcba, 24'hfe_dcba},
    {12'h453, 24'h34_5a5a, 24'h00_5a5a}, {12'h455, 24'h00_f001, 24'h00_f001},
    {12'h44d, 24'h00_1234, 24'h00_0000}};

  chb_fir_coeff_taps dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dual_mode(dual_mode), .sample(sample),
    .sample_valid(sample_valid), .y(y), .y_valid(y_valid));

  initial forever #10 clk = ~clk;

  // Hang guard, far above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end

  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wreg(input logic [11:0] a, input logic [23:0] d);
    @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 0;
  endtask : wreg

  // Read data stand one cycle only, so the idle zero is checked as well
  task rchk(input logic [11:0] a, input logic [23:0] e);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    @(negedge clk) chk("rdata", {10'h0, rdata}, {10'h0, e});
    @(negedge clk) chk("rdata_idle", {10'h0, rdata}, 34'h0);
  endtask : rchk

  task smp(input logic [11:0] s);
    @(posedge clk) begin sample_valid <= 1; sample <= s; end
    @(posedge clk) sample_valid <= 0;
    @(negedge clk);
  endtask : smp

  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    logic [23:0] d;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 9; i++) rchk(fir_pkg::TAP_OFFSETS[i], fir_pkg::COEF_RESET);
    foreach (rows[i]) begin
      wreg(rows[i][59:48], rows[i][47:24]);
      rchk(rows[i][59:48], rows[i][23:0]);
    end
    // Write then read with no gap between the strobes
    @(posedge clk) begin wr <= 1; addr <= 12'h44e; wdata <= 24'h5a_c3c3; end
    @(posedge clk) begin wr <= 0; rd <= 1; end
    @(posedge clk) rd <= 0;
    @(negedge clk) chk("rdata_b2b", {10'h0, rdata}, 34'h00_c3c3);
    // negative coefficients, center uses 18 bits with reserved bits set
    for (int i = 0; i < 9; i++) begin
      d = (i == 4) ? 24'hfe_0005 : 24'h00_0f00 + 24'(i);
      cf[i] = (i == 4) ? int'($signed(d[17:0])) : int'($signed(d[11:0]));
      wreg(fir_pkg::TAP_OFFSETS[i], d);
    end
    dual_mode <= 1;
    // impulse walks through all nine taps, newest sample on the first
    for (int i = 0; i < 10; i++) begin
      smp((i == 0) ? 12'h7ff : 12'h000);
      chk("y_valid", {33'h0, y_valid}, 34'h1);
      chk("y", y, (i < 9) ? 34'(cf[i] * 2047) : 34'h0);
    end
    // leaving dual mode silences and clears the filter
    smp(12'h7ff);
    @(posedge clk) dual_mode <= 0;
    smp(12'h7ff);
    chk("y_single", y, 34'h0);
    chk("y_valid_single", {33'h0, y_valid}, 34'h0);
    @(posedge clk) dual_mode <= 1;
    smp(12'h000);
    chk("y_cleared", y, 34'h0);
    // reset in mid-run clears the coefficients
    @(posedge clk) rst_n <= 0;
    @(posedge clk) rst_n <= 1;
    @(negedge clk) chk("y_reset", y, 34'h0);
    rchk(12'h450, 24'h00_0000);
    complete_run;
  end
endmodule : chb_fir_coeff_taps_tb
